// file: rtl/qprc_mem.sv
// byte array behind the read datapath, read data registered
// assumes: single clock, one write and one read per cycle
`timescale 1ns/10ps
module qprc_mem #(
  parameter int AW = 8
) (
  input  wire logic   MCLK,
  qprc_mem_if.store   mem
);
  logic [7:0] arr_ff [0:(1<<AW)-1];
  logic [7:0] rdata_ff;

  always_ff @(posedge MCLK)
  begin
    if (mem.we)
      arr_ff[mem.waddr] <= mem.wdata;
    rdata_ff <= arr_ff[mem.raddr];
  end

  assign mem.rdata = rdata_ff;
endmodule : qprc_mem

// file: rtl/qprc_sync.sv
// two-flop synchroniser for pins arriving from outside the MCLK domain
// assumes: pins are quasi-static levels; RST_B is synchronous to MCLK
`timescale 1ns/10ps
module qprc_sync #(
  parameter int          W       = 6,
  parameter logic [5:0]  RST_VAL = 6'h3f
) (
  input  wire logic         MCLK,
  input  wire logic         RST_B,
  input  wire logic [W-1:0] d_in,
  output wire logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      meta_ff <= RST_VAL[W-1:0];
      sync_ff <= RST_VAL[W-1:0];
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule : qprc_sync

// file: rtl/qprc_top.sv
// qpi mode and read-parameter command engine with an ahb-lite register slave
// assumes: host drives CS_B/SCLK/IO_IN asynchronously, SCLK well below MCLK/4
//
// Overview of operation
// - unique-id opcode takes 32 bits of dummy, then id shifts out on falling edges
// - the 64-bit id is fixed at build time and nothing can write it
// - read-parameter setup is ignored in serial mode, accepted only in qpi mode
// - qpi dummy field 00/01/10/11 gives 2/4/6/8 dummy clocks for reads
// - wrap field 00/01/10/11 gives an 8/16/32/64 byte wrap window
// - after reset the wrap window is 8 bytes and qpi dummy count is 2
// - serial reads use the serial dummy field; wrap comes from wrap-setup bits
// - wrap setting is kept unchanged across any mode switch
// - wrapped read acts as fast read in qpi mode only (ignored in serial), address wraps inside its aligned window
// - serial and qpi modes are exclusive; serial mode after power-up
// - enter-qpi switches only when quad enable is set, else ignored
// - enter-qpi is the only way from serial into qpi mode
// - exit-qpi in qpi mode returns to serial mode
// - write-enable latch and suspend flag survive every mode switch
`timescale 1ns/10ps
module qprc_top
  import qprc_pkg::*;
#(
  parameter int          AW  = 8,
  parameter logic [63:0] UID = 64'h0123_4567_89ab_cdef  // arbitrary value
) (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output wire logic [31:0] HRDATA,
  output wire logic        HREADYOUT,
  output wire logic        HRESP,
  input  wire logic        CS_B,
  input  wire logic        SCLK,
  input  wire logic [3:0]  IO_IN,
  output wire logic [3:0]  IO_OUT,
  output wire logic [3:0]  IO_OE_B
);
`include "qprc_defines.svh"

  qprc_mem_if #(.AW(AW)) mif ();

  // pins, synchronised; edges found on the synced copy only
  logic [5:0]  pin_s;
  logic [1:0]  pin_d_ff;
  // reset value matches the idle pins (clock low), so no false edge follows reset
  qprc_sync #(.W(6), .RST_VAL(6'h2f)) u_sync (
    .MCLK  (MCLK),
    .RST_B (RST_B),
    .d_in  ({CS_B, SCLK, IO_IN}),
    .q_out (pin_s)
  );
  qprc_mem #(.AW(AW)) u_mem (
    .MCLK (MCLK),
    .mem  (mif)
  );

  wire        cs_s      = pin_s[5];
  wire  [3:0] io_s      = pin_s[3:0];
  wire        sclk_rise = pin_s[4] & ~pin_d_ff[0];
  wire        sclk_fall = ~pin_s[4] & pin_d_ff[0];
  wire        cs_rise   = cs_s & ~pin_d_ff[1];

  // ahb-lite slave state
  logic [31:0]           hrdata_ff;
  logic                  hready_ff;
  logic                  wr_pend_ff;
  logic [7:0]            wr_off_ff;
  logic [`QPRC_CTRL_W-1:0] ctrl_ff;
  logic [AW-1:0]         madr_ff;

  // mode and read parameters
  logic       qpi_ff;
  qprc_code_t qdum_ff;
  qprc_code_t wrap_ff;

  // command engine
  qprc_state_e st_ff, nxt_st;
  logic [6:0]  bits_ff, nxt_bits;
  logic [23:0] sh_ff, nxt_sh;
  logic [7:0]  cmd_ff, nxt_cmd;
  logic [6:0]  dum_ff, nxt_dum;
  logic [23:0] rda_ff, nxt_rda;
  logic [63:0] osh_ff, nxt_osh;
  logic [2:0]  obit_ff, nxt_obit;
  logic [3:0]  iout_ff, nxt_iout;
  logic [3:0]  ioe_ff, nxt_ioe;
  logic        isid_ff, nxt_isid;
  logic        isw_ff, nxt_isw;
  logic        par_ff, nxt_par;

  // bus decode
  wire        ap_valid = HSEL & HTRANS[1] & HREADY;
  wire  [7:0] ap_off   = HADDR[7:0];
  wire [31:0] stat_val = {25'h000_0000, ctrl_ff[`QPRC_C_SUS], ctrl_ff[`QPRC_C_WEL],
                          wrap_ff, qdum_ff, qpi_ff};
  wire [31:0] rd_val   = (ap_off == `QPRC_A_CTRL)  ? {27'h000_0000, ctrl_ff} :
                         (ap_off == `QPRC_A_STAT)  ? stat_val :
                         (ap_off == `QPRC_A_MADR)  ? {{(32-AW){1'b0}}, madr_ff} :
                         (ap_off == `QPRC_A_UIDLO) ? UID[31:0] :
                         (ap_off == `QPRC_A_UIDHI) ? UID[63:32] : 32'h0000_0000;
  wire        wr_ctrl  = wr_pend_ff & (wr_off_ff == `QPRC_A_CTRL);
  wire        wr_madr  = wr_pend_ff & (wr_off_ff == `QPRC_A_MADR);
  wire        wr_mdat  = wr_pend_ff & (wr_off_ff == `QPRC_A_MDAT);

  assign mif.we    = wr_mdat;
  assign mif.waddr = madr_ff;
  assign mif.wdata = HWDATA[7:0];
  assign mif.raddr = rda_ff[AW-1:0];

  // command helpers
  wire  [6:0] step     = qpi_ff ? 7'h04 : 7'h01;
  wire [23:0] sh_in    = qpi_ff ? {sh_ff[19:0], io_s} : {sh_ff[22:0], io_s[0]};
  wire  [6:0] bits_n   = bits_ff + step;
  wire  [7:0] op_n     = sh_in[7:0];
  wire  [1:0] dum_code = qpi_ff ? qdum_ff : ctrl_ff[`QPRC_C_SDUM];
  wire  [6:0] rd_dum   = {4'h0, dum_code, 1'b0} + `QPRC_DUMMY_BASE;
  wire  [6:0] uid_dum  = qpi_ff ? (`QPRC_UID_DUM_BITS >> 2) : `QPRC_UID_DUM_BITS;
  wire [23:0] wmask    = isw_ff ? ((`QPRC_WRAP_UNIT << wrap_ff) - 24'h00_0001)
                                : 24'hff_ffff;
  wire [23:0] rda_inc  = (rda_ff & ~wmask) | ((rda_ff + 24'h00_0001) & wmask);
  wire        oload    = ~isid_ff & (obit_ff == 3'h0);
  wire [63:0] oword    = oload ? {mif.rdata, 56'h0} : osh_ff;
  wire        act      = cs_rise;
  wire        do_ent   = act & (cmd_ff == `QPRC_OP_ENTQPI) & ~qpi_ff & ctrl_ff[`QPRC_C_QE];
  wire        do_ext   = act & (cmd_ff == `QPRC_OP_EXTQPI) & qpi_ff;
  wire        do_setp  = act & (cmd_ff == `QPRC_OP_SETPAR) & par_ff & qpi_ff;
  wire        do_setw  = act & (cmd_ff == `QPRC_OP_SETWRAP) & par_ff & ~qpi_ff;
  wire        do_rst   = act & (cmd_ff == `QPRC_OP_RESET);

  always_comb
  begin
    nxt_st   = st_ff;
    nxt_bits = bits_ff;
    nxt_sh   = sh_ff;
    nxt_cmd  = cmd_ff;
    nxt_dum  = dum_ff;
    nxt_rda  = rda_ff;
    nxt_osh  = osh_ff;
    nxt_obit = obit_ff;
    nxt_iout = iout_ff;
    nxt_ioe  = ioe_ff;
    nxt_isid = isid_ff;
    nxt_isw  = isw_ff;
    nxt_par  = par_ff;
    if (cs_s)
    begin
      // frame ends: state, bit count, opcode and param flag restart, pins released
      nxt_st   = QPRC_ST_OP;
      nxt_bits = 7'h00;
      nxt_cmd  = 8'h00;
      nxt_par  = 1'b0;
      nxt_ioe  = 4'hf;
    end
    else if (sclk_rise)
    begin
      case (st_ff)
        QPRC_ST_OP:
        begin
          nxt_sh   = sh_in;
          nxt_bits = bits_n;
          if (bits_n == `QPRC_OP_BITS)
          begin
            nxt_bits = 7'h00;
            nxt_cmd  = op_n;
            nxt_isid = (op_n == `QPRC_OP_UID);
            nxt_isw  = (op_n == `QPRC_OP_WRAPRD);
            case (op_n)
              `QPRC_OP_UID:
              begin
                nxt_st  = QPRC_ST_DUMMY;
                nxt_dum = uid_dum;
              end
              `QPRC_OP_FREAD:   nxt_st = QPRC_ST_ADDR;
              `QPRC_OP_WRAPRD:  nxt_st = qpi_ff ? QPRC_ST_ADDR : QPRC_ST_IGN;
              `QPRC_OP_SETPAR:  nxt_st = qpi_ff ? QPRC_ST_PARAM : QPRC_ST_IGN;
              `QPRC_OP_SETWRAP: nxt_st = qpi_ff ? QPRC_ST_IGN : QPRC_ST_PARAM;
              default:          nxt_st = QPRC_ST_IGN;
            endcase
          end
        end
        QPRC_ST_ADDR:
        begin
          nxt_sh   = sh_in;
          nxt_bits = bits_n;
          if (bits_n == `QPRC_ADDR_BITS)
          begin
            nxt_rda = sh_in;
            nxt_st  = QPRC_ST_DUMMY;
            nxt_dum = rd_dum;
          end
        end
        QPRC_ST_PARAM:
        begin
          nxt_sh   = sh_in;
          nxt_bits = bits_n;
          if (bits_n == `QPRC_PAR_BITS)
          begin
            nxt_par = 1'b1;
            nxt_st  = QPRC_ST_IGN;
          end
        end
        QPRC_ST_DUMMY:
        begin
          nxt_dum = dum_ff - 7'h01;
          if (dum_ff == 7'h01)
          begin
            nxt_st   = QPRC_ST_DATA;
            nxt_obit = 3'h0;
            nxt_osh  = UID;
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (sclk_fall && (st_ff == QPRC_ST_DATA))
    begin
      // output changes on the falling edge, msb first
      nxt_iout = qpi_ff ? oword[63:60] : {2'b00, oword[63], 1'b0};
      nxt_osh  = qpi_ff ? {oword[59:0], 4'h0} : {oword[62:0], 1'b0};
      nxt_obit = obit_ff + step[2:0];
      nxt_ioe  = qpi_ff ? 4'h0 : 4'hd;
      if (oload)
        nxt_rda = rda_inc;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      st_ff   <= QPRC_ST_OP;
      bits_ff <= 7'h00;
      sh_ff   <= 24'h00_0000;
      cmd_ff  <= 8'h00;
      dum_ff  <= 7'h00;
      rda_ff  <= 24'h00_0000;
      osh_ff  <= 64'h0000_0000_0000_0000;
      obit_ff <= 3'h0;
      iout_ff <= 4'h0;
      ioe_ff  <= 4'hf;
      isid_ff <= 1'b0;
      isw_ff  <= 1'b0;
      par_ff  <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      bits_ff <= nxt_bits;
      sh_ff   <= nxt_sh;
      cmd_ff  <= nxt_cmd;
      dum_ff  <= nxt_dum;
      rda_ff  <= nxt_rda;
      osh_ff  <= nxt_osh;
      obit_ff <= nxt_obit;
      iout_ff <= nxt_iout;
      ioe_ff  <= nxt_ioe;
      isid_ff <= nxt_isid;
      isw_ff  <= nxt_isw;
      par_ff  <= nxt_par;
    end
  end

  // mode and parameters change only at the end of a frame
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      qpi_ff  <= 1'b0;
      qdum_ff <= `QPRC_DUMMY_DEF;
      wrap_ff <= `QPRC_WRAP_DEF;
    end
    else if (do_rst)
    begin
      qdum_ff <= `QPRC_DUMMY_DEF;
      wrap_ff <= `QPRC_WRAP_DEF;
    end
    else
    begin
      if (do_ent)
        qpi_ff <= 1'b1;
      else if (do_ext)
        qpi_ff <= 1'b0;
      if (do_setp)
      begin
        qdum_ff <= sh_ff[`QPRC_P_DUMMY];
        wrap_ff <= sh_ff[`QPRC_P_WRAP];
      end
      else if (do_setw)
        wrap_ff <= sh_ff[`QPRC_W_WRAP];
    end
  end

  // ahb-lite: zero wait states, read data registered in the address phase
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      pin_d_ff   <= 2'h2;
      hrdata_ff  <= 32'h0000_0000;
      hready_ff  <= 1'b1;
      wr_pend_ff <= 1'b0;
      wr_off_ff  <= 8'h00;
      ctrl_ff    <= {`QPRC_CTRL_W{1'b0}};
      madr_ff    <= {AW{1'b0}};
    end
    else
    begin
      pin_d_ff   <= pin_s[5:4];
      hready_ff  <= 1'b1;
      wr_pend_ff <= ap_valid & HWRITE;
      wr_off_ff  <= ap_off;
      if (ap_valid & ~HWRITE)
        hrdata_ff <= rd_val;
      // wel and sus belong to the bus side only, a mode switch never touches them
      if (wr_ctrl)
        ctrl_ff <= HWDATA[`QPRC_CTRL_W-1:0];
      if (wr_madr)
        madr_ff <= HWDATA[AW-1:0];
      else if (wr_mdat)
        madr_ff <= madr_ff + {{(AW-1){1'b0}}, 1'b1};
    end
  end

  assign HRDATA    = hrdata_ff;
  assign HREADYOUT = hready_ff;
  assign HRESP     = 1'b0 & hready_ff;
  assign IO_OUT    = iout_ff;
  assign IO_OE_B   = ioe_ff;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  chk_enter_needs_qe: assert property ($rose(qpi_ff) |-> $past(ctrl_ff[`QPRC_C_QE]))
    else $error("qpi entered with quad enable clear");
  chk_enter_only_cmd: assert property ($rose(qpi_ff) |-> $past(cmd_ff) == `QPRC_OP_ENTQPI)
    else $error("qpi entered by something other than enter-qpi");
  chk_exit_qpi_cmd: assert property (do_ext |=> !qpi_ff)
    else $error("exit-qpi did not return to serial mode");
  chk_setpar_serial: assert property (act && !qpi_ff && cmd_ff == `QPRC_OP_SETPAR
                                      |=> $stable(qdum_ff) && $stable(wrap_ff))
    else $error("read parameters changed in serial mode");
  chk_wrap_kept_mode: assert property ($changed(qpi_ff) |-> $stable(wrap_ff))
    else $error("wrap length changed on mode switch");
  chk_wel_sus_kept: assert property ($changed(qpi_ff) && !$past(wr_ctrl)
                                     |-> $stable(ctrl_ff[`QPRC_C_SUS:`QPRC_C_WEL]))
    else $error("wel or suspend lost on mode switch");
  chk_reset_defaults: assert property ($past(RST_B) == 1'b0
                                       |-> !qpi_ff && qdum_ff == 2'h0 && wrap_ff == 2'h0)
    else $error("defaults wrong after reset");
  chk_wrap_window: assert property (st_ff == QPRC_ST_DATA && isw_ff && $changed(rda_ff)
                                    |-> (($past(rda_ff) ^ rda_ff) & ~wmask) == 24'h00_0000)
    else $error("wrapped read left its window");
  chk_read_dummy: assert property (st_ff == QPRC_ST_DUMMY && $past(st_ff) == QPRC_ST_ADDR
                                   |-> dum_ff == (dum_code == 2'h0 ? 7'h02 :
                                                  dum_code == 2'h1 ? 7'h04 :
                                                  dum_code == 2'h2 ? 7'h06 : 7'h08))
    else $error("wrong dummy clock count");
  chk_uid_first_bit: assert property (sclk_fall && st_ff == QPRC_ST_DATA && isid_ff && !qpi_ff
                                      && osh_ff == UID |=> iout_ff[1] == UID[63])
    else $error("id msb not first");

  cov_enter_qpi: cover property ($rose(qpi_ff));
  cov_wrap_read: cover property (st_ff == QPRC_ST_DATA && isw_ff && $changed(rda_ff));
  cov_uid_read:  cover property (st_ff == QPRC_ST_DATA && isid_ff);
  cov_set_param: cover property (do_setp);
endmodule : qprc_top

// file: shared/qprc_defines.svh
// opcodes, register offsets, field positions and reset values of the qpi read-parameter block
// assumes: included by bare name, after the package
`ifndef QPRC_DEFINES_SVH
`define QPRC_DEFINES_SVH
`define QPRC_OP_UID        8'h4b
`define QPRC_OP_FREAD      8'h0b
`define QPRC_OP_WRAPRD     8'h0c
`define QPRC_OP_SETPAR     8'hc0
`define QPRC_OP_SETWRAP    8'h77
`define QPRC_OP_ENTQPI     8'h38
`define QPRC_OP_EXTQPI     8'hff
`define QPRC_OP_RESET      8'h99
`define QPRC_OP_BITS       7'h08
`define QPRC_ADDR_BITS     7'h18
`define QPRC_PAR_BITS      7'h08
`define QPRC_UID_DUM_BITS  7'h20
`define QPRC_DUMMY_BASE    7'h02
`define QPRC_DUMMY_DEF     2'h0
`define QPRC_WRAP_DEF      2'h0
`define QPRC_WRAP_UNIT     24'h00_0008
`define QPRC_P_DUMMY       5:4
`define QPRC_P_WRAP        1:0
`define QPRC_W_WRAP        6:5
`define QPRC_A_CTRL        8'h00
`define QPRC_A_STAT        8'h04
`define QPRC_A_MADR        8'h08
`define QPRC_A_MDAT        8'h0c
`define QPRC_A_UIDLO       8'h10
`define QPRC_A_UIDHI       8'h14
`define QPRC_C_QE          0
`define QPRC_C_SDUM        2:1
`define QPRC_C_WEL         3
`define QPRC_C_SUS         4
`define QPRC_CTRL_W        5
`endif

// file: shared/qprc_mem_if.sv
// write and registered-read port between the command engine and the array memory
// assumes: one clock, the engine owns the read address, the ahb slave owns the write address, data and strobe
`timescale 1ns/10ps
interface qprc_mem_if #(parameter int AW = 8);
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [7:0]    wdata;
  logic          we;
  logic [7:0]    rdata;
  modport engine (output waddr, output raddr, output wdata, output we, input rdata);
  modport store  (input waddr, input raddr, input wdata, input we, output rdata);
endinterface : qprc_mem_if

// file: shared/qprc_pkg.sv
// types shared by the qpi read-parameter block
// assumes: compiled before every other file of the block
package qprc_pkg;
  typedef enum logic [5:0]
  {
    QPRC_ST_OP    = 6'h01,
    QPRC_ST_ADDR  = 6'h02,
    QPRC_ST_PARAM = 6'h04,
    QPRC_ST_DUMMY = 6'h08,
    QPRC_ST_DATA  = 6'h10,
    QPRC_ST_IGN   = 6'h20
  } qprc_state_e;
  typedef logic [1:0] qprc_code_t;
endpackage : qprc_pkg

// file: sim/qprc_host.sv
// behavioural host serial-flash controller driving the chip select, link clock and data lines
// assumes: 125 ns link period, lines released between frames and during dummy/data
`timescale 1ns/10ps
module qprc_host (
  output logic            cs_b,
  output logic            sclk,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_b
);
  // 8 MHz stays below the slowest read limit of every dummy setting
  localparam realtime HALF = 62.5;
  logic [3:0] oe_seen;
  // a released line reads back inverted, so a stale driven level never passes as data
  wire logic [3:0] line_v = io_out ^ io_oe_b;
  // no program or erase is ever issued, so the power-up write delay never gates a frame
  initial
  begin
    cs_b    = 1'b1;
    sclk    = 1'b0;
    io_in   = 4'h5;
    oe_seen = 4'hf;
  end
  task start_frame();
    begin
      cs_b <= 1'b0;
      #HALF;
    end
  endtask : start_frame
  // long high time lets mode and parameter updates land before the next bus read
  task end_frame();
    begin
      #HALF;
      io_in <= ~io_in;
      cs_b  <= 1'b1;
      #300;
    end
  endtask : end_frame
  task send(input bit qpi, input int nbits, input logic [63:0] v);
    int k;
    begin
      k = nbits - 1;
      while (k >= 0)
      begin
        if (qpi)
          io_in <= v[k -: 4];
        else
          io_in <= {~io_in[3:1], v[k]};
        k = k - (qpi ? 4 : 1);
        #HALF sclk <= 1'b1;
        #HALF sclk <= 1'b0;
      end
    end
  endtask : send
  // released lines toggle every clock so a stale level is never mistaken for data
  task recv(input bit qpi, input int nbits, output logic [63:0] v);
    int k;
    begin
      v = '0;
      k = 0;
      while (k < nbits)
      begin
        io_in <= ~io_in;
        #HALF;
        if (qpi)
          v = {v[59:0], line_v};
        else
          v = {v[62:0], line_v[1]};
        oe_seen = io_oe_b;
        k = k + (qpi ? 4 : 1);
        sclk <= 1'b1;
        #HALF sclk <= 1'b0;
      end
    end
  endtask : recv
endmodule : qprc_host

// file: sim/testbench.sv
// self-checking bench: ahb-lite master plus host model around the qpi command engine
// assumes: the one slave's hreadyout is the bus hready; flash lines come from qprc_host
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module testbench;
  localparam logic [63:0] UID_V = 64'h5a5a_0f0f_c3c3_9696; // arbitrary value
  logic        mclk, rst_b, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, r;
  wire  logic [31:0] hrdata;
  wire  logic        hready, hresp, cs_b, sclk;
  wire  logic [3:0]  io_in, io_out, io_oe_b;
  int          miscompares, tests_run, cyc, i, b;
  logic [7:0]  mem_m [256];
  logic [7:0]  p;
  logic [23:0] a;
  logic [63:0] v;
  qprc_top #(.AW(8), .UID(UID_V)) u_qprc_top (.MCLK(mclk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CS_B(cs_b),
    .SCLK(sclk), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_B(io_oe_b));
  qprc_host u_qprc_host (.cs_b(cs_b), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe_b(io_oe_b));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] exp_stat(logic q, logic [1:0] d, logic [1:0] w,
                                           logic write_enable_latch, logic suspend_flag);
    return {25'h0, suspend_flag, write_enable_latch, w, d, q};
  endfunction : exp_stat
  function automatic int n_dummy(int code);
    return 2 * code + 2;
  endfunction : n_dummy
  function automatic logic [7:0] wrap_addr(logic [7:0] s, int w, int k);
    int win;
    win = 8 << w;
    return 8'((int'(s) & ~(win - 1)) | ((int'(s) + k) & (win - 1)));
  endfunction : wrap_addr
  // single word transfer; address phase held until hready, data taken at the second edge
  task ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    begin
      @(posedge mclk);
      haddr  <= ad;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      r = hrdata;
    end
  endtask : ahb
  task cmd(input bit q, input logic [7:0] op, input bit has_par, input logic [7:0] par);
    begin
      u_qprc_host.start_frame();
      u_qprc_host.send(q, 8, op);
      if (has_par)
        u_qprc_host.send(q, 8, par);
      u_qprc_host.end_frame();
    end
  endtask : cmd
  task summarize();
    begin
      $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask : summarize
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    {hsel, htrans, hwrite, hsize, haddr, hwdata} = {1'b1, 2'b00, 1'b0, 3'b010, 64'h0};
    rst_b = 1'b0;
    void'($urandom(32'h0681_5a8c));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(0, 0, 0, 0, 0))
    ahb(1'b0, 32'h20, 32'h0);
    `CHK(r, 32'h0000_0000)
    $display("test reset done");
    ahb(1'b1, 32'h10, 32'hffff_ffff);
    `CHK(hresp, 1'b0)
    ahb(1'b0, 32'h10, 32'h0);
    `CHK(r, UID_V[31:0])
    ahb(1'b0, 32'h14, 32'h0);
    `CHK(r, UID_V[63:32])
    u_qprc_host.start_frame();
    u_qprc_host.send(1'b0, 8, 8'h4b);
    u_qprc_host.recv(1'b0, 32, v);
    u_qprc_host.recv(1'b0, 64, v);
    u_qprc_host.end_frame();
    `CHK(v, UID_V)
    `CHK(u_qprc_host.oe_seen, 4'b1101)
    `CHK(io_oe_b, 4'hf)
    $display("test unique id done");
    cmd(1'b0, 8'hc0, 1'b1, 8'h33);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(0, 0, 0, 0, 0))
    cmd(1'b0, 8'h38, 1'b0, 8'h00);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(0, 0, 0, 0, 0))
    cmd(1'b0, 8'h77, 1'b1, 8'h60);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(0, 0, 3, 0, 0))
    $display("test serial commands done");
    ahb(1'b1, 32'h08, 32'h0);
    for (i = 0; i < 256; i++)
    begin
      mem_m[i] = 8'($urandom);
      ahb(1'b1, 32'h0c, {24'h0, mem_m[i]});
    end
    ahb(1'b1, 32'h00, 32'h0000_001d);
    a = 24'($urandom);
    u_qprc_host.start_frame();
    u_qprc_host.send(1'b0, 8, 8'h0b);
    u_qprc_host.send(1'b0, 24, a);
    u_qprc_host.recv(1'b0, n_dummy(2), v);
    u_qprc_host.recv(1'b0, 16, v);
    u_qprc_host.end_frame();
    `CHK(v[15:0], {mem_m[a[7:0]], mem_m[8'(a[7:0] + 8'd1)]})
    cmd(1'b0, 8'h38, 1'b0, 8'h00);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(1, 0, 3, 1, 1))
    $display("test serial read and entry done");
    for (i = 0; i < 4; i++)
    begin
      p = 8'($urandom);
      p[5:4] = 2'(3 - i);
      p[1:0] = 2'(i);
      cmd(1'b1, 8'hc0, 1'b1, p);
      ahb(1'b0, 32'h04, 32'h0);
      `CHK(r, exp_stat(1, 2'(3 - i), 2'(i), 1, 1))
      a = 24'($urandom);
      u_qprc_host.start_frame();
      u_qprc_host.send(1'b1, 8, 8'h0c);
      u_qprc_host.send(1'b1, 24, a);
      u_qprc_host.recv(1'b0, n_dummy(3 - i), v);
      for (b = 0; b < (8 << i) + 2; b++)
      begin
        u_qprc_host.recv(1'b1, 8, v);
        `CHK(v[7:0], mem_m[wrap_addr(a[7:0], i, b)])
      end
      u_qprc_host.end_frame();
      `CHK(u_qprc_host.oe_seen, 4'b0000)
    end
    u_qprc_host.start_frame();
    u_qprc_host.send(1'b1, 8, 8'h4b);
    u_qprc_host.recv(1'b0, 8, v);
    u_qprc_host.recv(1'b1, 64, v);
    u_qprc_host.end_frame();
    `CHK(v, UID_V)
    cmd(1'b1, 8'h77, 1'b1, 8'h00);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(1, 0, 3, 1, 1))
    $display("test qpi wrapped reads done");
    cmd(1'b1, 8'hff, 1'b0, 8'h00);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(0, 0, 3, 1, 1))
    cmd(1'b0, 8'h99, 1'b0, 8'h00);
    ahb(1'b0, 32'h04, 32'h0);
    `CHK(r, exp_stat(0, 0, 0, 1, 1))
    $display("test exit and reset instruction done");
    summarize();
  end
endmodule : testbench
